// >>> verilog/poc_pkg.sv
package poc_pkg;

	// clock and pulse timing
	localparam int CLK_HZ = 40_000_000;
	localparam int PULSE_LOW_MS = 80;
	localparam int PULSE_LOW_CYC = PULSE_LOW_MS * (CLK_HZ / 1000);
	localparam int PULSE_CNT_W = 22;
	localparam int NUM_PINS = 4;

	// register indices, byte address is four times the index
	localparam logic [13:0] IDX_OC_STATUS = 14'h048F;
	localparam logic [13:0] IDX_PULSE_MODE = 14'h0490;
	localparam logic [13:0] IDX_PHASE_SEL = 14'h0491;
	localparam logic [13:0] IDX_PIN_CFG = 14'h0481;
	localparam logic [13:0] IDX_IRQ_STATUS = 14'h04A0;
	localparam logic [13:0] IDX_IRQ_MASK = 14'h04A1;

	// field positions
	localparam int PIN4_FN_LSB = 2;
	localparam int PIN3_FN_BIT = 1;
	localparam int SOFT_RESET_TRIGGER_BIT = 0;
	localparam int DIS_LSB = 12;
	localparam int SEL_W = 3;
	localparam int PHASE_SEL_W = 12;
	localparam int OC_W = 4;

	// pin 4 function codes
	localparam logic [1:0] FN4_EVENT = 2'h2;
	localparam logic [1:0] FN4_DATA_READY_INDICATOR = 2'h3;

	// energy type codes; codes from the alias value upward mean total active
	localparam logic [2:0] EN_TOTAL_ACTIVE = 3'h0;
	localparam logic [2:0] EN_ALIAS_FIRST = 3'h6;

	// reset values
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [11:0] PHASE_SEL_RST = 12'h000;
	localparam logic [1:0] FN4_RST = 2'h0;
	localparam logic FN3_RST = 1'b0;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [3:0] STATUS_RST = 4'h0;

	// pulse shaper states
	typedef enum logic [1:0] {
		SH_IDLE = 2'b00,
		SH_LOW = 2'b01,
		SH_GAP = 2'b10
	} poc_shape_state_t;

endpackage

// >>> verilog/poc_pulse_shaper.sv
module poc_pulse_shaper #(
	parameter int LOW_CYCLES = poc_pkg::PULSE_LOW_CYC
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// converter pulse request
	input wire logic trig_i,
	// shaped active low pulse
	output logic pulse_n_o
);

	typedef struct packed {
		poc_pkg::poc_shape_state_t state;
		logic [poc_pkg::PULSE_CNT_W-1:0] cnt;
		logic out_n;
	} poc_shaper_st_t;

	localparam logic [poc_pkg::PULSE_CNT_W-1:0] CNT_LOAD = poc_pkg::PULSE_CNT_W'(LOW_CYCLES - 1);

	poc_shaper_st_t st_reg;
	poc_shaper_st_t st_next;

	// low phase of fixed width; a new request cuts it short with a one cycle high gap
	always_comb begin
		st_next = st_reg;
		case (st_reg.state)
			poc_pkg::SH_IDLE: begin
				if (trig_i) begin
					st_next.state = poc_pkg::SH_LOW;
					st_next.cnt = CNT_LOAD;
				end
			end
			poc_pkg::SH_LOW: begin
				if (trig_i) begin
					st_next.state = poc_pkg::SH_GAP;
				end else if (st_reg.cnt == '0) begin
					st_next.state = poc_pkg::SH_IDLE;
				end else begin
					st_next.cnt = st_reg.cnt - 1'b1;
				end
			end
			poc_pkg::SH_GAP: begin
				st_next.state = poc_pkg::SH_LOW;
				st_next.cnt = CNT_LOAD;
			end
			default: begin
				st_next.state = poc_pkg::SH_IDLE;
			end
		endcase
		st_next.out_n = (st_next.state != poc_pkg::SH_LOW);
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_reg <= '{state: poc_pkg::SH_IDLE, cnt: '0, out_n: 1'b1};
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign pulse_n_o = st_reg.out_n;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	property p_low_start;
		(ce_i && st_reg.state == poc_pkg::SH_IDLE && trig_i) |=> (!pulse_n_o && st_reg.cnt == CNT_LOAD);
	endproperty
	a_low_start: assert property (p_low_start) else $error("pulse did not start low with full width");

	property p_low_hold;
		(ce_i && !pulse_n_o && st_reg.cnt != '0 && !trig_i) |=> !pulse_n_o;
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("pulse ended before its width");

	c_low_end: cover property (ce_i && st_reg.state == poc_pkg::SH_LOW && st_reg.cnt == '0);
endmodule

// >>> verilog/poc_pulse_output_config.sv
// What this block does
// - the pin-4 function field at bits 3:2 routes the converter pulse for 00 and 01, the event for 10, data ready for 11.
// - the pin-3 function bit 1 routes the converter pulse when 0 and the selected zero crossing when 1.
// - writing one to soft reset bit 0 starts a software reset and the bit clears itself.
// - the read-only overcurrent field bits 3:0 shows phases A, B, C and neutral above the threshold.
// - disable bit 15 stops pulses on pin 4 and holds that pin high.
// - a disabled pin never sets its pulse flag in the status register.
// - disable bits 14, 13 and 12 do the same for pins 3, 2 and 1.
// - the pin-4 energy code maps 000..101 to the six energy types and 110, 111 to total active.
// - energy codes at bits 8:6, 5:3 and 2:0 choose the type for pins 3, 2 and 1 the same way.
// - phase bits 11:9 add phase C, B and A to pin 4 for bits 2, 1 and 0.
// - phase bits 5:3 and 2:0 choose the phases of pins 2 and 1 the same way.
// - pulses are active low and their low width is fixed at 80 ms.
//
// Decided for this implementation: the APB interface to the registers.
module poc_pulse_output_config #(
	parameter int PULSE_LOW_CYCLES = poc_pkg::PULSE_LOW_CYC
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// core sources
	input wire logic [3:0] dfc_pulse_i,
	input wire logic event_i,
	input wire logic data_ready_i,
	input wire logic zero_cross_i,
	input wire logic [3:0] overcurrent_phase_i,
	// pins and configuration outputs
	output logic [3:0] pulse_out_o,
	output logic [11:0] pulse_energy_type_o,
	output logic [11:0] pulse_phase_mask_o,
	output logic soft_reset_o,
	output logic irq_o
);

	typedef struct packed {
		logic [15:0] mode;
		logic [11:0] phase_sel;
		logic [1:0] fn4;
		logic fn3;
		logic [3:0] mask;
		logic [3:0] status;
		logic [3:0] pins;
		logic [11:0] etype;
		logic [11:0] pmask;
		logic soft_reset_trigger;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} poc_cfg_st_t;

	poc_cfg_st_t st_reg;
	poc_cfg_st_t st_next;

	logic [3:0] disable_bits;
	logic [3:0] trig;
	logic [3:0] shaped_n;
	logic setup_ph;
	logic done_ph;
	logic aligned;
	logic sel_oc;
	logic sel_mode;
	logic sel_phase;
	logic sel_cfg;
	logic sel_ist;
	logic sel_imsk;
	logic hit;
	logic [31:0] rdata;
	logic [3:0] clr;

	// energy code decode, unused codes fold onto total active
	function automatic logic [2:0] energy_decode(input logic [2:0] code);
		energy_decode = (code >= poc_pkg::EN_ALIAS_FIRST) ? poc_pkg::EN_TOTAL_ACTIVE : code;
	endfunction

	// disable bits 15..12 belong to pins 4..1
	assign disable_bits = st_reg.mode[poc_pkg::DIS_LSB +: 4];
	assign trig = dfc_pulse_i & ~disable_bits;

	// one pulse shaper per pin
	genvar g;
	generate
		for (g = 0; g < poc_pkg::NUM_PINS; g++) begin : g_shaper
			poc_pulse_shaper #(
				.LOW_CYCLES(PULSE_LOW_CYCLES)
			) u_shaper (
				.clk_i(clk_i),
				.srst_i(srst_i),
				.ce_i(ce_i),
				.trig_i(trig[g]),
				.pulse_n_o(shaped_n[g])
			);
		end
	endgenerate

	// apb phase and address decode
	assign setup_ph = psel_i && !penable_i && !st_reg.pready;
	assign done_ph = psel_i && penable_i && st_reg.pready;
	assign aligned = (paddr_i[1:0] == 2'h0);
	assign sel_oc = aligned && (paddr_i[15:2] == poc_pkg::IDX_OC_STATUS);
	assign sel_mode = aligned && (paddr_i[15:2] == poc_pkg::IDX_PULSE_MODE);
	assign sel_phase = aligned && (paddr_i[15:2] == poc_pkg::IDX_PHASE_SEL);
	assign sel_cfg = aligned && (paddr_i[15:2] == poc_pkg::IDX_PIN_CFG);
	assign sel_ist = aligned && (paddr_i[15:2] == poc_pkg::IDX_IRQ_STATUS);
	assign sel_imsk = aligned && (paddr_i[15:2] == poc_pkg::IDX_IRQ_MASK);
	assign hit = sel_oc || sel_mode || sel_phase || sel_cfg || sel_ist || sel_imsk;

	// read mux; reserved bits and the soft reset bit read zero
	always_comb begin
		rdata = 32'h0000_0000;
		if (sel_oc) begin
			rdata[poc_pkg::OC_W-1:0] = overcurrent_phase_i;
		end
		if (sel_mode) begin
			rdata[15:0] = st_reg.mode;
		end
		if (sel_phase) begin
			rdata[poc_pkg::PHASE_SEL_W-1:0] = st_reg.phase_sel;
		end
		if (sel_cfg) begin
			rdata[poc_pkg::PIN4_FN_LSB +: 2] = st_reg.fn4;
			rdata[poc_pkg::PIN3_FN_BIT] = st_reg.fn3;
			rdata[poc_pkg::SOFT_RESET_TRIGGER_BIT] = 1'b0;
		end
		if (sel_ist) begin
			rdata[3:0] = st_reg.status;
		end
		if (sel_imsk) begin
			rdata[3:0] = st_reg.mask;
		end
	end

	// only the status bits that were returned are cleared by the read
	assign clr = (done_ph && !pwrite_i && sel_ist) ? st_reg.prdata[3:0] : 4'h0;

	// next state of registers, pins and bus answer
	always_comb begin
		st_next = st_reg;
		st_next.soft_reset_trigger = 1'b0;
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;
		if (setup_ph) begin
			st_next.pready = 1'b1;
			st_next.pslverr = !hit;
			st_next.prdata = (hit && !pwrite_i) ? rdata : 32'h0000_0000;
		end
		if (done_ph && pwrite_i && hit) begin
			if (sel_mode) begin
				st_next.mode = pwdata_i[15:0];
			end
			if (sel_phase) begin
				st_next.phase_sel = pwdata_i[poc_pkg::PHASE_SEL_W-1:0];
			end
			if (sel_imsk) begin
				st_next.mask = pwdata_i[3:0];
			end
			if (sel_cfg) begin
				st_next.fn4 = pwdata_i[poc_pkg::PIN4_FN_LSB +: 2];
				st_next.fn3 = pwdata_i[poc_pkg::PIN3_FN_BIT];
				if (pwdata_i[poc_pkg::SOFT_RESET_TRIGGER_BIT]) begin
					st_next.soft_reset_trigger = 1'b1;
					st_next.mode = poc_pkg::MODE_RST;
					st_next.phase_sel = poc_pkg::PHASE_SEL_RST;
					st_next.fn4 = poc_pkg::FN4_RST;
					st_next.fn3 = poc_pkg::FN3_RST;
					st_next.mask = poc_pkg::MASK_RST;
				end
			end
		end
		// sticky pulse flags: a new pulse wins over a clear
		st_next.status = (st_reg.status & ~clr) | trig;
		if (st_next.soft_reset_trigger) begin
			st_next.status = poc_pkg::STATUS_RST | trig;
		end
		// pins 1 and 2 carry only the shaped converter pulse
		for (int k = 0; k < 2; k++) begin
			st_next.pins[k] = disable_bits[k] | shaped_n[k];
		end
		// pin 3 carries the converter pulse or the zero crossing
		if (disable_bits[2]) begin
			st_next.pins[2] = 1'b1;
		end else if (st_reg.fn3) begin
			st_next.pins[2] = zero_cross_i;
		end else begin
			st_next.pins[2] = shaped_n[2];
		end
		// pin 4 carries the converter pulse, the event or data ready
		if (disable_bits[3]) begin
			st_next.pins[3] = 1'b1;
		end else begin
			case (st_reg.fn4)
				poc_pkg::FN4_EVENT: st_next.pins[3] = event_i;
				poc_pkg::FN4_DATA_READY_INDICATOR: st_next.pins[3] = data_ready_i;
				default: st_next.pins[3] = shaped_n[3];
			endcase
		end
		// decoded energy types and phase masks per pin
		for (int k = 0; k < poc_pkg::NUM_PINS; k++) begin
			st_next.etype[k*poc_pkg::SEL_W +: poc_pkg::SEL_W] =
				energy_decode(st_next.mode[k*poc_pkg::SEL_W +: poc_pkg::SEL_W]);
			st_next.pmask[k*poc_pkg::SEL_W +: poc_pkg::SEL_W] =
				st_next.phase_sel[k*poc_pkg::SEL_W +: poc_pkg::SEL_W];
		end
		st_next.irq = |(st_next.status & st_next.mask);
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_reg <= '{mode: poc_pkg::MODE_RST, phase_sel: poc_pkg::PHASE_SEL_RST, fn4: poc_pkg::FN4_RST,
				fn3: poc_pkg::FN3_RST, mask: poc_pkg::MASK_RST, status: poc_pkg::STATUS_RST, pins: 4'hF,
				etype: 12'h000, pmask: 12'h000, soft_reset_trigger: 1'b0, irq: 1'b0, pready: 1'b0, pslverr: 1'b0,
				prdata: 32'h0000_0000};
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign prdata_o = st_reg.prdata;
	assign pready_o = st_reg.pready;
	assign pslverr_o = st_reg.pslverr;
	assign pulse_out_o = st_reg.pins;
	assign pulse_energy_type_o = st_reg.etype;
	assign pulse_phase_mask_o = st_reg.pmask;
	assign soft_reset_o = st_reg.soft_reset_trigger;
	assign irq_o = st_reg.irq;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	property p_fn4_event;
		(ce_i && !disable_bits[3] && st_reg.fn4 == poc_pkg::FN4_EVENT) |=> (pulse_out_o[3] == $past(event_i));
	endproperty
	a_fn4_event: assert property (p_fn4_event) else $error("pin 4 does not follow the event");

	property p_fn3_zx;
		(ce_i && !disable_bits[2] && st_reg.fn3) |=> (pulse_out_o[2] == $past(zero_cross_i));
	endproperty
	a_fn3_zx: assert property (p_fn3_zx) else $error("pin 3 does not follow the zero crossing");

	property p_soft_reset_trigger;
		(ce_i && done_ph && pwrite_i && sel_cfg && pwdata_i[0]) |=> (soft_reset_o && st_reg.mode == 16'h0000)
			##1 (!soft_reset_o || !$past(ce_i));
	endproperty
	a_soft_reset_trigger: assert property (p_soft_reset_trigger) else $error("soft reset not a self clearing pulse");

	property p_oc_read;
		(ce_i && setup_ph && !pwrite_i && sel_oc) |=> (prdata_o == {28'h0000000, $past(overcurrent_phase_i)});
	endproperty
	a_oc_read: assert property (p_oc_read) else $error("overcurrent read does not show phases");

	property p_disable_high;
		(ce_i && |disable_bits) |=> ((pulse_out_o & $past(disable_bits)) == $past(disable_bits));
	endproperty
	a_disable_high: assert property (p_disable_high) else $error("disabled pin not held high");

	property p_no_flag;
		ce_i |=> ((st_reg.status & ~$past(st_reg.status) & $past(disable_bits)) == 4'h0);
	endproperty
	a_no_flag: assert property (p_no_flag) else $error("disabled pin set its pulse flag");

	property p_energy4;
		ce_i |=> (pulse_energy_type_o[11:9] ==
			(($past(st_next.mode[11:9]) >= 3'h6) ? 3'h0 : $past(st_next.mode[11:9])));
	endproperty
	a_energy4: assert property (p_energy4) else $error("pin 4 energy type decoded wrongly");

	property p_energy_alias;
		pulse_energy_type_o[2:0] < 3'h6 && pulse_energy_type_o[5:3] < 3'h6 && pulse_energy_type_o[8:6] < 3'h6;
	endproperty
	a_energy_alias: assert property (p_energy_alias) else $error("unused energy code leaked");

	property p_phase;
		(ce_i && done_ph && pwrite_i && sel_phase) |=> (pulse_phase_mask_o == $past(pwdata_i[11:0]));
	endproperty
	a_phase: assert property (p_phase) else $error("phase mask not taken from write");

	property p_soft_reset_trigger_reads_zero;
		(ce_i && setup_ph && !pwrite_i && sel_cfg) |=> (prdata_o[0] == 1'b0);
	endproperty
	a_soft_reset_trigger_reads_zero: assert property (p_soft_reset_trigger_reads_zero) else $error("soft reset bit read as one");

	property p_ce_freeze;
		!ce_i |=> $stable(st_reg);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");

	c_event_route: cover property (ce_i && st_reg.fn4 == poc_pkg::FN4_EVENT && event_i);
	c_status_clear: cover property (ce_i && done_ph && !pwrite_i && sel_ist && |st_reg.prdata[3:0]);
	c_soft_reset_trigger: cover property (soft_reset_o);
	c_irq: cover property (irq_o);
endmodule

// >>> sim/poc_pulse_meter.sv
module poc_pulse_meter (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// observed pulse pins
	input wire logic [3:0] pins_i,
	// falls per pin (4 bits each), last low width per pin (8 bits each)
	output logic [15:0] falls_o,
	output logic [31:0] width_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] prev;
	logic [31:0] run;
	// count low cycles, latch the width when a pin returns high
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			prev <= 4'hF;
			run <= '0;
			falls_o <= '0;
			width_o <= '0;
		end else begin
			prev <= pins_i;
			for (int k = 0; k < 4; k++) begin
				if (prev[k] && !pins_i[k])
					falls_o[4*k +: 4] <= falls_o[4*k +: 4] + 4'h1;
				if (!pins_i[k]) begin
					run[8*k +: 8] <= run[8*k +: 8] + 8'h01;
				end else if (!prev[k]) begin
					width_o[8*k +: 8] <= run[8*k +: 8];
					run[8*k +: 8] <= 8'h00;
				end
			end
		end
	end
endmodule

// >>> sim/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LOWC = 8;
	localparam logic [15:0] A_OC = {poc_pkg::IDX_OC_STATUS, 2'b00};
	localparam logic [15:0] A_MODE = {poc_pkg::IDX_PULSE_MODE, 2'b00};
	localparam logic [15:0] A_PH = {poc_pkg::IDX_PHASE_SEL, 2'b00};
	localparam logic [15:0] A_CFG = {poc_pkg::IDX_PIN_CFG, 2'b00};
	localparam logic [15:0] A_ST = {poc_pkg::IDX_IRQ_STATUS, 2'b00};
	localparam logic [15:0] A_MSK = {poc_pkg::IDX_IRQ_MASK, 2'b00};
	logic clk_i = 0, srst_i = 1, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic event_i = 0, data_ready_i = 0, zero_cross_i = 0;
	logic [15:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic [3:0] dfc_pulse_i = '0, overcurrent_phase_i = '0;
	logic [31:0] prdata_o, width;
	logic pready_o, pslverr_o, soft_reset_o, irq_o;
	logic [3:0] pulse_out_o;
	logic [11:0] pulse_energy_type_o, pulse_phase_mask_o;
	logic [15:0] falls;
	int err_total = 0, compares = 0, sr_cnt = 0;
	// design and pulse counting equipment
	poc_pulse_output_config #(.PULSE_LOW_CYCLES(LOWC)) poc_pulse_output_config_i (.clk_i(clk_i),
		.srst_i(srst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .dfc_pulse_i(dfc_pulse_i), .event_i(event_i), .data_ready_i(data_ready_i),
		.zero_cross_i(zero_cross_i), .overcurrent_phase_i(overcurrent_phase_i), .pulse_out_o(pulse_out_o),
		.pulse_energy_type_o(pulse_energy_type_o), .pulse_phase_mask_o(pulse_phase_mask_o),
		.soft_reset_o(soft_reset_o), .irq_o(irq_o));
	poc_pulse_meter poc_pulse_meter_i (.clk_i(clk_i), .srst_i(srst_i), .pins_i(pulse_out_o),
		.falls_o(falls), .width_o(width));
	// clock and soft reset pulse counter
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (soft_reset_o === 1'b1) sr_cnt++;
	task automatic report_and_stop();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one apb transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic er);
		int n;
		@(posedge clk_i);
		psel_i <= 1;
		penable_i <= 0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		r = prdata_o;
		er = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
		if (pready_o !== 1'b1) begin
			err_total++;
			$display("MISMATCH t=%0t apb transfer timed out", $time);
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1, a, d, r, e);
		repeat (2) @(posedge clk_i);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(0, a, 0, r, e);
		chk(r, x);
		chk(e, 0);
	endtask
	task automatic fire(input int k);
		@(posedge clk_i);
		dfc_pulse_i <= 4'h1 << k;
		@(posedge clk_i);
		dfc_pulse_i <= 4'h0;
		repeat (LOWC + 4) @(posedge clk_i);
	endtask
	// reset values, unmapped and unaligned access
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		chk(pulse_out_o, 4'hF);
		rd(A_OC, 0);
		rd(A_MODE, 0);
		rd(A_PH, 0);
		rd(A_CFG, 0);
		rd(A_ST, 0);
		rd(A_MSK, 0);
		apb(0, 16'h0004, 0, r, e);
		chk(e, 1);
		apb(1, A_MODE + 16'h0002, 32'hFFFF, r, e);
		chk(e, 1);
		rd(A_MODE, 0);
	endtask
	// energy codes on all pins, phase masks bit by bit
	task automatic t_fields();
		logic [2:0] c, x;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			x = (i > 5) ? 3'h0 : c;
			wr(A_MODE, {20'h0, c, c, c, c});
			chk(pulse_energy_type_o, {4{x}});
			rd(A_MODE, {20'h0, c, c, c, c});
		end
		for (int k = 0; k < 12; k++) begin
			wr(A_PH, 32'h1 << k);
			chk(pulse_phase_mask_o, 12'h1 << k);
		end
		wr(A_PH, 32'hFFFFFFFF);
		rd(A_PH, 32'h0FFF);
		wr(A_MODE, 0);
	endtask
	// overcurrent flags per phase, writes ignored
	task automatic t_oc();
		for (int k = 0; k < 4; k++) begin
			overcurrent_phase_i <= 4'h1 << k;
			wr(A_OC, 32'hF);
			rd(A_OC, 32'h1 << k);
		end
		overcurrent_phase_i <= 4'h0;
	endtask
	// pulse width, flags, interrupt, disable and mask
	task automatic t_pulse();
		wr(A_MSK, 32'hF);
		for (int k = 0; k < 4; k++) begin
			fire(k);
			chk(width[8*k +: 8], LOWC);
			chk(falls[4*k +: 4], 1);
			chk(irq_o, 1);
			rd(A_ST, 32'h1 << k);
			repeat (2) @(posedge clk_i);
			chk(irq_o, 0);
			rd(A_ST, 0);
		end
		wr(A_MODE, 32'hF000);
		for (int k = 0; k < 4; k++) begin
			fire(k);
			chk(falls[4*k +: 4], 1);
			rd(A_ST, 0);
		end
		wr(A_MODE, 0);
		wr(A_MSK, 0);
		fire(0);
		chk(irq_o, 0);
		rd(A_ST, 1);
	endtask
	// clock enable low freezes a pulse in the middle of its width
	task automatic t_ce();
		@(posedge clk_i);
		dfc_pulse_i <= 4'h1;
		@(posedge clk_i);
		dfc_pulse_i <= 4'h0;
		@(posedge clk_i);
		ce_i <= 0;
		repeat (LOWC + 4) @(posedge clk_i);
		chk(pulse_out_o[0], 0);
		ce_i <= 1;
		repeat (LOWC + 4) @(posedge clk_i);
		chk(width[7:0], LOWC + LOWC + 4);
		rd(A_ST, 1);
	endtask
	// pin functions for pins 3 and 4
	task automatic t_fn();
		logic [3:0] f;
		data_ready_i <= 1;
		zero_cross_i <= 1;
		for (int i = 0; i < 4; i++) begin
			wr(A_CFG, i << 2);
			chk(pulse_out_o[3], i != 2);
		end
		wr(A_CFG, 32'h4);
		f = falls[15:12];
		fire(3);
		chk(falls[15:12], f + 4'h1);
		wr(A_CFG, 32'h2);
		chk(pulse_out_o[2], 1);
		zero_cross_i <= 0;
		repeat (3) @(posedge clk_i);
		chk(pulse_out_o[2], 0);
		wr(A_CFG, 32'h8);
		event_i <= 1;
		repeat (3) @(posedge clk_i);
		chk(pulse_out_o[3], 1);
		event_i <= 0;
		wr(A_MODE, 32'h8000);
		chk(pulse_out_o[3], 1);
	endtask
	// soft reset pulse and register clearing
	task automatic t_soft_reset_trigger();
		int s;
		wr(A_MODE, 32'h1234);
		wr(A_MSK, 32'h3);
		s = sr_cnt;
		wr(A_CFG, 32'hD);
		chk(sr_cnt - s, 1);
		rd(A_CFG, 0);
		rd(A_MODE, 0);
		rd(A_MSK, 0);
		wr(A_CFG, 32'hC);
		rd(A_CFG, 32'hC);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		srst_i <= 0;
		t_reset();
		t_fields();
		t_oc();
		t_pulse();
		t_ce();
		t_fn();
		t_soft_reset_trigger();
		report_and_stop();
	end
endmodule
